// *** design/error_status_service_request.sv ***
// Purpose: error event registers, status byte and service request
// Assumes: command, poll and status sources are on the block clock
// Notes:   fault pins are synchronised before use
`timescale 1ns/1ps
module error_status_service_request #(
    parameter longint unsigned SHUTDOWN_DELAY = esr_pkg::SHUTDOWN_CYCLES
) (
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire logic              overheat_pin,
    input  wire logic              overvolt_pin,
    input  wire logic              conv_comm_fail_pin,
    input  wire logic              board_fail_pin,
    input  wire logic              interlock_fault_pin,
    input  wire logic              supply_flow_pin,
    input  wire logic              magnet_flow_pin,
    input  wire logic              line_high_pin,
    input  wire logic              line_low_pin,
    input  wire logic              temp_high_pin,
    input  wire logic              bad_trim_pin,
    input  wire logic [15:0]       measured_ma,
    input  wire logic              ext_prog_refused,
    input  wire logic              operation_summary,
    input  wire logic              event_summary,
    input  wire logic              outbuf_not_empty,
    input  wire esr_pkg::cmd_type  cmd,
    output esr_pkg::resp_type      resp,
    input  wire logic              serial_poll,
    output logic [7:0]             poll_byte,
    output logic                   srq,
    input  wire logic              setpoint_wr,
    input  wire logic [15:0]       setpoint_data,
    output logic [15:0]            current_setpoint,
    output logic                   setpoint_locked,
    output logic                   shutdown
);
    logic [4:0]                hw_pins_sync;
    logic [6:0]                op_pins_sync;
    logic [7:0]                hw_set;
    logic [7:0]                op_set;
    logic [7:0]                hw_error_events;
    logic [7:0]                operational_error_events;
    logic [7:0]                hw_enable_q;
    logic [7:0]                op_enable_q;
    logic [7:0]                request_enable_mask;
    logic [7:0]                summary_status_byte;
    logic [7:0]                summary_only;
    logic                      hw_error_summary;
    logic                      op_error_summary;
    logic                      master_summary;
    logic                      master_summary_q;
    logic                      rqs_q;
    logic                      rqs_d;
    logic                      error_clear;
    logic                      is_read;
    logic                      is_clear_all;
    logic                      overcurrent;
    esr_pkg::resp_type         resp_d;
    logic [15:0]               setpoint_q;
    logic [15:0]               setpoint_d;
    esr_pkg::heat_state_type   heat_q;
    esr_pkg::heat_state_type   heat_d;
    logic [31:0]               heat_count_q;
    logic                      heat_done;
    logic [7:0]                poll_byte_d;

    function automatic logic cmd_is(input esr_pkg::cmd_type c,
                                    input esr_pkg::cmd_code_type k);
        return c.valid && (c.code == k);
    endfunction

    // fault pins cross into the clock domain
    sync_two #(.WIDTH(5)) u_hw_sync (
        .clock    (clock),
        .arst_n   (arst_n),
        .async_in ({overheat_pin, overvolt_pin, 1'b0, conv_comm_fail_pin, board_fail_pin}),
        .sync_out (hw_pins_sync)
    );

    sync_two #(.WIDTH(7)) u_op_sync (
        .clock    (clock),
        .arst_n   (arst_n),
        .async_in ({interlock_fault_pin, supply_flow_pin, magnet_flow_pin, line_high_pin,
                    line_low_pin, temp_high_pin, bad_trim_pin}),
        .sync_out (op_pins_sync)
    );

    // event sources per bit
    assign overcurrent = measured_ma > esr_pkg::CURRENT_LIMIT_MA;
    assign hw_set[esr_pkg::HW_OVERHEAT_BIT]    = hw_pins_sync[esr_pkg::HW_OVERHEAT_BIT];
    assign hw_set[esr_pkg::HW_OVERVOLT_BIT]    = hw_pins_sync[esr_pkg::HW_OVERVOLT_BIT];
    assign hw_set[esr_pkg::HW_OVERCURRENT_BIT] = overcurrent;
    assign hw_set[esr_pkg::HW_CONV_COMM_BIT]   = hw_pins_sync[esr_pkg::HW_CONV_COMM_BIT];
    assign hw_set[esr_pkg::HW_BOARD_FAIL_BIT]  = hw_pins_sync[esr_pkg::HW_BOARD_FAIL_BIT];
    assign hw_set[7:5] = 3'h0;
    assign op_set[esr_pkg::OP_INTERLOCK_BIT]   = op_pins_sync[6];
    assign op_set[esr_pkg::OP_SUPPLY_FLOW_BIT] = op_pins_sync[5];
    assign op_set[esr_pkg::OP_MAGNET_FLOW_BIT] = op_pins_sync[4];
    assign op_set[esr_pkg::OP_LINE_HIGH_BIT]   = op_pins_sync[3];
    assign op_set[esr_pkg::OP_LINE_LOW_BIT]    = op_pins_sync[2];
    assign op_set[esr_pkg::OP_TEMP_HIGH_BIT]   = op_pins_sync[1];
    assign op_set[esr_pkg::OP_EXT_PROG_BIT]    = ext_prog_refused;
    assign op_set[esr_pkg::OP_BAD_TRIM_BIT]    = op_pins_sync[0];

    // command decode
    assign is_read      = cmd_is(cmd, esr_pkg::CMD_ERROR_READ);
    assign is_clear_all = cmd_is(cmd, esr_pkg::CMD_CLEAR_STATUS);
    assign error_clear  = is_read || is_clear_all;

    // sticky error event registers, read-clear
    event_latch #(.WIDTH(8)) u_hw_events (
        .clock    (clock),
        .arst_n   (arst_n),
        .set_in   (hw_set),
        .clear    (error_clear),
        .events_q (hw_error_events)
    );

    event_latch #(.WIDTH(8)) u_op_events (
        .clock    (clock),
        .arst_n   (arst_n),
        .set_in   (op_set),
        .clear    (error_clear),
        .events_q (operational_error_events)
    );

    // summary bits are pure combinational functions of their sources
    assign hw_error_summary = |(hw_error_events & hw_enable_q);
    assign op_error_summary = |(operational_error_events & op_enable_q);
    assign summary_only = {operation_summary, 1'b0, event_summary, outbuf_not_empty,
                           1'b0, hw_error_summary, op_error_summary, 1'b0};
    assign master_summary = |(summary_only & request_enable_mask
                              & esr_pkg::STB_SUMMARY_MASK);
    assign summary_status_byte = summary_only
                                 | ({7'h00, master_summary} << esr_pkg::STB_REQUEST_BIT);

    // request function: set on rising master summary, cleared by poll
    assign rqs_d = (master_summary && !master_summary_q) ? 1'b1
                 : serial_poll ? 1'b0 : rqs_q;
    assign srq   = rqs_q;

    assign poll_byte_d = (summary_only & ~(8'h01 << esr_pkg::STB_REQUEST_BIT))
                         | ({7'h00, rqs_q} << esr_pkg::STB_REQUEST_BIT);

    // query answers, one per code
    always_comb begin
        resp_d = '0;
        case (1'b1)
            is_read: begin
                resp_d = {1'b1, hw_error_events, operational_error_events};
            end
            cmd_is(cmd, esr_pkg::CMD_ERROR_EN_QRY): begin
                resp_d = {1'b1, hw_enable_q, op_enable_q};
            end
            cmd_is(cmd, esr_pkg::CMD_REQ_EN_QRY): begin
                resp_d = {1'b1, 8'h00, request_enable_mask};
            end
            cmd_is(cmd, esr_pkg::CMD_STATUS_QRY): begin
                resp_d = {1'b1, 8'h00, summary_status_byte};
            end
            default: begin
                resp_d = '0;
            end
        endcase
    end

    // enable masks, written by command
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hw_enable_q         <= esr_pkg::REG_RESET;
            op_enable_q         <= esr_pkg::REG_RESET;
            request_enable_mask <= esr_pkg::REG_RESET;
        end else if (cmd_is(cmd, esr_pkg::CMD_ERROR_ENABLE)) begin
            hw_enable_q <= cmd.data[15:8] & esr_pkg::HW_USED_MASK;
            op_enable_q <= cmd.data[7:0];
        end else if (cmd_is(cmd, esr_pkg::CMD_REQ_ENABLE)) begin
            request_enable_mask <= cmd.data[7:0];
        end
    end

    // edge memory, request, answer and poll capture
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            master_summary_q <= 1'b0;
            rqs_q            <= 1'b0;
            resp             <= '0;
            poll_byte        <= esr_pkg::REG_RESET;
        end else begin
            master_summary_q <= master_summary;
            rqs_q            <= rqs_d;
            resp             <= resp_d;
            poll_byte        <= serial_poll ? poll_byte_d : poll_byte;
        end
    end

    // setpoint lock on temperature high or refused external programming
    assign setpoint_locked = operational_error_events[esr_pkg::OP_TEMP_HIGH_BIT]
                           | operational_error_events[esr_pkg::OP_EXT_PROG_BIT];
    assign setpoint_d = setpoint_locked ? esr_pkg::SETPOINT_ZERO
                      : setpoint_wr ? setpoint_data : setpoint_q;
    assign current_setpoint = setpoint_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            setpoint_q <= esr_pkg::SETPOINT_ZERO;
        end else begin
            setpoint_q <= setpoint_d;
        end
    end

    // overheat shutdown timer
    assign heat_done = heat_count_q >= 32'(SHUTDOWN_DELAY - 1);

    always_comb begin
        case (heat_q)
            esr_pkg::HEAT_IDLE: begin
                heat_d = hw_error_events[esr_pkg::HW_OVERHEAT_BIT]
                       ? esr_pkg::HEAT_COUNT : esr_pkg::HEAT_IDLE;
            end
            esr_pkg::HEAT_COUNT: begin
                heat_d = heat_done ? esr_pkg::HEAT_OFF : esr_pkg::HEAT_COUNT;
            end
            esr_pkg::HEAT_OFF: begin
                heat_d = esr_pkg::HEAT_OFF;
            end
            default: begin
                heat_d = esr_pkg::HEAT_IDLE;
            end
        endcase
    end

    assign shutdown = heat_q == esr_pkg::HEAT_OFF;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            heat_q       <= esr_pkg::HEAT_IDLE;
            heat_count_q <= 32'h0000_0000;
        end else begin
            heat_q       <= heat_d;
            heat_count_q <= (heat_q == esr_pkg::HEAT_COUNT) ? heat_count_q + 32'h0000_0001
                                                             : 32'h0000_0000;
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    overcurrent_sets_a: assert property (overcurrent |=>
        hw_error_events[esr_pkg::HW_OVERCURRENT_BIT])
        else $error("overcurrent flag not set");

    read_clears_a: assert property ((is_read && !(|hw_set) && !(|op_set)) |=>
        (hw_error_events == 8'h00 && operational_error_events == 8'h00))
        else $error("error read did not clear");

    read_data_a: assert property (is_read |=>
        resp.valid && resp.data == {$past(hw_error_events), $past(operational_error_events)})
        else $error("error read answer wrong");

    summary_live_a: assert property (summary_status_byte[esr_pkg::STB_HW_ERROR_BIT]
        == |(hw_error_events & hw_enable_q))
        else $error("hardware summary mismatch");

    unused_zero_a: assert property (summary_status_byte[3] == 1'b0
        && hw_error_events[7:5] == 3'h0)
        else $error("unused bit set");

    srq_rise_a: assert property ($rose(master_summary) |=> srq)
        else $error("no request on rising summary");

    poll_clears_a: assert property ((serial_poll && !(master_summary && !master_summary_q))
        |=> !srq)
        else $error("poll did not clear request");

    no_new_req_a: assert property ((!rqs_q && master_summary_q && master_summary) |=> !rqs_q)
        else $error("request raised without new rise");

    lock_zero_a: assert property (setpoint_locked |=> current_setpoint == 16'h0000)
        else $error("setpoint not zeroed");

    shut_bound_a: assert property ((heat_q == esr_pkg::HEAT_COUNT) |->
        heat_count_q < 32'(SHUTDOWN_DELAY))
        else $error("shutdown late");

    stb_keep_a: assert property (cmd_is(cmd, esr_pkg::CMD_STATUS_QRY) && !serial_poll
        && !$rose(master_summary) |=> rqs_q == $past(rqs_q))
        else $error("status query changed request");

    clear_all_a: assert property ((is_clear_all && !(|hw_set) && !(|op_set)) |=>
        (hw_error_events == esr_pkg::REG_RESET
         && operational_error_events == esr_pkg::REG_RESET))
        else $error("clear status did not clear");

    upper_bits_a: assert property (summary_status_byte[esr_pkg::STB_OPERATION_BIT]
        == operation_summary
        && summary_status_byte[esr_pkg::STB_EVENT_BIT] == event_summary
        && summary_status_byte[esr_pkg::STB_MESSAGE_BIT] == outbuf_not_empty)
        else $error("status byte source bit wrong");

    op_summary_a: assert property ((operational_error_events & op_enable_q) != 8'h00
        |-> summary_status_byte[esr_pkg::STB_OP_ERROR_BIT])
        else $error("operational summary missing");

    mask_zero_a: assert property (request_enable_mask == esr_pkg::REG_RESET
        |-> !summary_status_byte[esr_pkg::STB_REQUEST_BIT])
        else $error("request bit without enables");

    req_write_a: assert property (cmd_is(cmd, esr_pkg::CMD_REQ_ENABLE) |=>
        request_enable_mask == $past(cmd.data[7:0]) && !resp.valid)
        else $error("request enable not written");

    poll_byte_a: assert property (serial_poll |=>
        poll_byte[esr_pkg::STB_REQUEST_BIT] == $past(rqs_q))
        else $error("poll byte request bit wrong");

    query_upper_a: assert property (cmd_is(cmd, esr_pkg::CMD_STATUS_QRY) |=>
        resp.valid && resp.data[15:8] == 8'h00)
        else $error("status query upper byte set");

    ext_lock_a: assert property (ext_prog_refused |=> setpoint_locked)
        else $error("refused programming not locked");

    shut_hold_a: assert property (shutdown |=> shutdown)
        else $error("shutdown released");

    // cycles spent with overheat latched and the output still on
    logic [31:0]               heat_age_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            heat_age_q <= 32'h0000_0000;
        end else if (hw_error_events[esr_pkg::HW_OVERHEAT_BIT] && !shutdown) begin
            heat_age_q <= heat_age_q + 32'h0000_0001;
        end
    end

    shut_latency_a: assert property (heat_age_q <= 32'(SHUTDOWN_DELAY + 1))
        else $error("overheat shutdown overdue");

    cover_srq_c:   cover property ($rose(srq));
    cover_poll_c:  cover property (srq ##1 serial_poll ##1 !srq);
    cover_read_c:  cover property (is_read && hw_error_events != 8'h00);
    cover_shut_c:  cover property ($rose(shutdown));
    cover_mss_c:   cover property (master_summary && !srq);
endmodule

// *** design/esr_pkg.sv ***
// Purpose: constants and types of the error status and service request block
// Assumes: one 20 MHz clock, power-on reset clears all registers but the heat state, which loads HEAT_IDLE
// Notes:   bit positions, limits and command codes live here, save the status byte bit order, which the summary_only concatenation fixes
package esr_pkg;
    localparam int unsigned HW_OVERHEAT_BIT    = 4;
    localparam int unsigned HW_OVERVOLT_BIT    = 3;
    localparam int unsigned HW_OVERCURRENT_BIT = 2;
    localparam int unsigned HW_CONV_COMM_BIT   = 1;
    localparam int unsigned HW_BOARD_FAIL_BIT  = 0;
    localparam logic [7:0]  HW_USED_MASK       = 8'h1F;
    localparam int unsigned OP_INTERLOCK_BIT   = 7;
    localparam int unsigned OP_SUPPLY_FLOW_BIT = 6;
    localparam int unsigned OP_MAGNET_FLOW_BIT = 5;
    localparam int unsigned OP_LINE_HIGH_BIT   = 4;
    localparam int unsigned OP_LINE_LOW_BIT    = 3;
    localparam int unsigned OP_TEMP_HIGH_BIT   = 2;
    localparam int unsigned OP_EXT_PROG_BIT    = 1;
    localparam int unsigned OP_BAD_TRIM_BIT    = 0;
    localparam int unsigned STB_OPERATION_BIT  = 7;
    localparam int unsigned STB_REQUEST_BIT    = 6;
    localparam int unsigned STB_EVENT_BIT      = 5;
    localparam int unsigned STB_MESSAGE_BIT    = 4;
    localparam int unsigned STB_HW_ERROR_BIT   = 2;
    localparam int unsigned STB_OP_ERROR_BIT   = 1;
    localparam logic [7:0]  STB_SUMMARY_MASK   = 8'hB6;
    localparam logic [7:0]  REG_RESET          = 8'h00;
    localparam logic [15:0] SETPOINT_ZERO      = 16'h0000;
    localparam logic [15:0] CURRENT_LIMIT_MA   = 16'hF230;
    localparam longint unsigned CLOCK_HZ        = 20000000;
    localparam longint unsigned SHUTDOWN_TIME_S = 10;
    localparam longint unsigned SHUTDOWN_CYCLES = SHUTDOWN_TIME_S * CLOCK_HZ;

    typedef enum logic [2:0] {
        CMD_ERROR_READ   = 3'h0,
        CMD_ERROR_ENABLE = 3'h1,
        CMD_ERROR_EN_QRY = 3'h2,
        CMD_REQ_ENABLE   = 3'h3,
        CMD_REQ_EN_QRY   = 3'h4,
        CMD_STATUS_QRY   = 3'h5,
        CMD_CLEAR_STATUS = 3'h6
    } cmd_code_type;

    typedef struct packed {
        logic         valid;
        cmd_code_type code;
        logic [15:0]  data;
    } cmd_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } resp_type;

    typedef enum logic [2:0] {
        HEAT_IDLE  = 3'b001,
        HEAT_COUNT = 3'b010,
        HEAT_OFF   = 3'b100
    } heat_state_type;
endpackage

// *** design/event_latch.sv ***
// Purpose: sticky event register with read-clear
// Assumes: set and clear come from the same clock
// Notes:   a set in the clearing cycle wins
`timescale 1ns/1ps
module event_latch #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] set_in,
    input  wire logic             clear,
    output logic      [WIDTH-1:0] events_q
);
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                events_q[i] <= 1'b0;
            end else if (set_in[i]) begin
                events_q[i] <= 1'b1;
            end else if (clear) begin
                events_q[i] <= 1'b0;
            end
        end
    end
endmodule

// *** design/sync_two.sv ***
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are quasi-static levels
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module sync_two #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// *** testbench/bus_controller_model.sv ***
// Purpose: bus controller model issuing commands and serial polls
// Assumes: block takes a command on the edge after it is driven
// Notes:   answer is sampled just after the taking edge
`timescale 1ns/1ps
module bus_controller_model (
    input  wire logic              clock,
    input  wire esr_pkg::resp_type resp,
    output esr_pkg::cmd_type       cmd,
    output logic                   serial_poll
);
    initial begin
        cmd         = '0;
        serial_poll = 1'b0;
    end

    // one command, held for the taking edge; no answer reads as unknown
    task automatic issue(input esr_pkg::cmd_code_type k, input logic [15:0] d,
                         output logic [15:0] rd);
        @(posedge clock);
        cmd <= '{valid: 1'b1, code: k, data: d};
        @(posedge clock);
        cmd <= '0;
        #1;
        rd = (resp.valid === 1'b1) ? resp.data : 16'hxxxx;
    endtask

    task automatic poll();
        @(posedge clock);
        serial_poll <= 1'b1;
        @(posedge clock);
        serial_poll <= 1'b0;
        #1;
    endtask

    // clear events, then enable weight 32 for a request on standard events
    task automatic arm_event_request();
        logic [15:0] rd;
        issue(esr_pkg::CMD_CLEAR_STATUS, 16'h0000, rd);
        issue(esr_pkg::CMD_REQ_ENABLE, 16'h0020, rd);
    endtask
endmodule

// *** testbench/error_status_service_request_bench.sv ***
// Purpose: self-checking bench of the error status and request block
// Assumes: shutdown delay shortened to eight cycles
// Notes:   table rows cover every fault source, then hand-made cases
`timescale 1ns/1ps
module error_status_service_request_bench;
    typedef struct packed {
        logic [10:0] pins;
        logic [15:0] ma;
        logic        ext;
        logic [15:0] exp;
    } row_type;
    logic              clock;
    logic              arst_n;
    logic [10:0]       pins;
    logic [15:0]       measured_ma;
    logic              ext_prog_refused;
    logic              operation_summary;
    logic              event_summary;
    logic              outbuf_not_empty;
    logic              setpoint_wr;
    logic [15:0]       setpoint_data;
    esr_pkg::cmd_type  cmd;
    esr_pkg::resp_type resp;
    logic              serial_poll;
    logic [7:0]        poll_byte;
    logic              srq;
    logic [15:0]       current_setpoint;
    logic              setpoint_locked;
    logic              shutdown;
    logic [15:0]       rd;
    int                errors;
    int                tests_run;
    int                cycles;
    row_type           rows [14];

    error_status_service_request #(.SHUTDOWN_DELAY(8)) u_error_status_service_request (
        .clock(clock), .arst_n(arst_n),
        .overheat_pin(pins[10]), .overvolt_pin(pins[9]),
        .conv_comm_fail_pin(pins[8]), .board_fail_pin(pins[7]),
        .interlock_fault_pin(pins[6]), .supply_flow_pin(pins[5]),
        .magnet_flow_pin(pins[4]), .line_high_pin(pins[3]),
        .line_low_pin(pins[2]), .temp_high_pin(pins[1]), .bad_trim_pin(pins[0]),
        .measured_ma(measured_ma), .ext_prog_refused(ext_prog_refused),
        .operation_summary(operation_summary), .event_summary(event_summary),
        .outbuf_not_empty(outbuf_not_empty), .cmd(cmd), .resp(resp),
        .serial_poll(serial_poll), .poll_byte(poll_byte), .srq(srq),
        .setpoint_wr(setpoint_wr), .setpoint_data(setpoint_data),
        .current_setpoint(current_setpoint), .setpoint_locked(setpoint_locked),
        .shutdown(shutdown)
    );
    bus_controller_model u_bus_controller_model (
        .clock(clock), .resp(resp), .cmd(cmd), .serial_poll(serial_poll)
    );

    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic q(input esr_pkg::cmd_code_type k, input logic [15:0] d);
        u_bus_controller_model.issue(k, d, rd);
    endtask
    task automatic drive(input logic [10:0] p, input logic [15:0] ma, input logic e);
        @(posedge clock);
        pins             <= p;
        measured_ma      <= ma;
        ext_prog_refused <= e;
    endtask
    task automatic sp_write(input logic [15:0] d);
        @(posedge clock);
        setpoint_wr   <= 1'b1;
        setpoint_data <= d;
        @(posedge clock);
        setpoint_wr <= 1'b0;
        #1;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        rows = '{'{11'h400, 16'h0000, 1'b0, 16'h1000}, '{11'h200, 16'h0000, 1'b0, 16'h0800},
                 '{11'h100, 16'h0000, 1'b0, 16'h0200}, '{11'h080, 16'h0000, 1'b0, 16'h0100},
                 '{11'h040, 16'h0000, 1'b0, 16'h0080}, '{11'h020, 16'h0000, 1'b0, 16'h0040},
                 '{11'h010, 16'h0000, 1'b0, 16'h0020}, '{11'h008, 16'h0000, 1'b0, 16'h0010},
                 '{11'h004, 16'h0000, 1'b0, 16'h0008}, '{11'h002, 16'h0000, 1'b0, 16'h0004},
                 '{11'h001, 16'h0000, 1'b0, 16'h0001}, '{11'h000, 16'hF231, 1'b0, 16'h0400},
                 '{11'h000, 16'hF230, 1'b0, 16'h0000}, '{11'h000, 16'h0000, 1'b1, 16'h0002}};
        {errors, tests_run, cycles} = '0;
        {pins, measured_ma, ext_prog_refused, setpoint_wr, setpoint_data} = '0;
        {operation_summary, event_summary, outbuf_not_empty} = '0;
        arst_n = 1'b0;
        step(4);
        check("reset_outputs", {resp.valid, srq, shutdown, current_setpoint[12:0]}, 16'h0000);
        arst_n <= 1'b1;
        q(esr_pkg::CMD_STATUS_QRY, 16'h0000);
        check("status_idle", rd, 16'h0000);
        foreach (rows[i]) begin
            drive(rows[i].pins, rows[i].ma, rows[i].ext);
            step(5);
            drive(11'h000, 16'h0000, 1'b0);
            step(4);
            q(esr_pkg::CMD_ERROR_READ, 16'h0000);
            check("error_pair", rd, rows[i].exp);
            q(esr_pkg::CMD_ERROR_READ, 16'h0000);
            check("cleared_pair", rd, 16'h0000);
        end
        check("shutdown", 16'(shutdown), 16'h0001);
        q(esr_pkg::CMD_ERROR_ENABLE, 16'hFFFF);
        q(esr_pkg::CMD_REQ_ENABLE, 16'h0004);
        q(esr_pkg::CMD_REQ_EN_QRY, 16'h0000);
        check("req_enable", rd, 16'h0004);
        q(esr_pkg::CMD_ERROR_EN_QRY, 16'h0000);
        check("err_enable", rd, 16'h1FFF);
        drive(11'h080, 16'h0000, 1'b0);
        step(6);
        check("srq_rise", 16'(srq), 16'h0001);
        q(esr_pkg::CMD_STATUS_QRY, 16'h0000);
        check("status_query", rd, 16'h0044);
        u_bus_controller_model.poll();
        check("poll_byte", 16'(poll_byte), 16'h0044);
        check("srq_polled", 16'(srq), 16'h0000);
        q(esr_pkg::CMD_STATUS_QRY, 16'h0000);
        check("master_kept", rd, 16'h0044);
        drive(11'h280, 16'h0000, 1'b0);
        step(6);
        check("no_new_srq", 16'(srq), 16'h0000);
        drive(11'h000, 16'h0000, 1'b0);
        step(4);
        q(esr_pkg::CMD_ERROR_READ, 16'h0000);
        check("read_pair", rd, 16'h0900);
        q(esr_pkg::CMD_STATUS_QRY, 16'h0000);
        check("summary_gone", rd, 16'h0000);
        drive(11'h200, 16'h0000, 1'b0);
        step(6);
        check("srq_again", 16'(srq), 16'h0001);
        drive(11'h000, 16'h0000, 1'b0);
        q(esr_pkg::CMD_REQ_ENABLE, 16'h0000);
        q(esr_pkg::CMD_STATUS_QRY, 16'h0000);
        check("req_disabled", rd, 16'h0004);
        q(esr_pkg::CMD_CLEAR_STATUS, 16'h0000);
        q(esr_pkg::CMD_STATUS_QRY, 16'h0000);
        check("clear_status", rd, 16'h0000);
        u_bus_controller_model.poll();
        q(esr_pkg::CMD_ERROR_ENABLE, 16'h00FF);
        q(esr_pkg::CMD_REQ_ENABLE, 16'h0006);
        drive(11'h081, 16'h0000, 1'b0);
        step(6);
        q(esr_pkg::CMD_STATUS_QRY, 16'h0000);
        check("hw_masked", rd, 16'h0042);
        drive(11'h000, 16'h0000, 1'b0);
        step(4);
        q(esr_pkg::CMD_ERROR_READ, 16'h0000);
        u_bus_controller_model.poll();
        u_bus_controller_model.arm_event_request();
        @(posedge clock);
        {operation_summary, event_summary, outbuf_not_empty} <= 3'b111;
        step(3);
        check("event_srq", 16'(srq), 16'h0001);
        q(esr_pkg::CMD_STATUS_QRY, 16'h0000);
        check("upper_bits", rd, 16'h00F0);
        @(posedge clock);
        {operation_summary, event_summary, outbuf_not_empty} <= 3'b000;
        step(2);
        q(esr_pkg::CMD_STATUS_QRY, 16'h0000);
        check("message_gone", rd, 16'h0000);
        sp_write(16'h1234);
        check("setpoint", current_setpoint, 16'h1234);
        drive(11'h002, 16'h0000, 1'b0);
        step(6);
        sp_write(16'h0055);
        check("locked_zero", {current_setpoint[14:0], setpoint_locked}, 16'h0001);
        drive(11'h000, 16'h0000, 1'b1);
        step(2);
        sp_write(16'h0055);
        check("ext_locked", {current_setpoint[14:0], setpoint_locked}, 16'h0001);
        drive(11'h000, 16'h0000, 1'b0);
        step(4);
        q(esr_pkg::CMD_ERROR_READ, 16'h0000);
        check("lock_causes", rd, 16'h0006);
        sp_write(16'h0055);
        check("unlocked", current_setpoint, 16'h0055);
        wrap_up();
    end
endmodule
